// ==== hw/fsh_ctl.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsh_ctl import fsh_pkg::*; #(
	parameter logic [7:0]  MAKER_ID  = 8'h5A,  // Arbitrary value
	parameter logic [7:0]  DEV_ID    = 8'h33,  // Arbitrary value
	parameter logic [15:0] JEDEC_DEV = 16'h4C21 // Arbitrary value
)(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        cs_n_in,
	input  wire logic        sclk_in,
	input  wire logic [3:0]  dq_in,
	output logic      [3:0]  dq_out,
	output logic      [3:0]  dq_oe_out,
	input  wire logic        array_busy_in,
	input  wire logic        write_done_in,
	input  wire logic        otp_mode_in,
	input  wire logic        deep_pd_in,
	input  wire logic [5:0]  status_hi_in,
	input  wire logic [7:0]  mem_data_in,
	output logic      [23:0] mem_addr_out,
	output logic             cmd_valid_out,
	output logic      [7:0]  cmd_opcode_out,
	output logic             rx_valid_out,
	output logic      [7:0]  rx_byte_out,
	output logic             frame_end_out,
	output logic             sw_reset_out,
	output logic             otp_exit_out,
	output logic             four_lane_mode_out,
	output logic             quad_read_continuation_out,
	output logic             write_permit_out,
	output logic             busy_out
);
	// ==========================================
	// Lane helpers
	function automatic logic [3:0] bw(input fsh_lane_e l);
		case (l)
			LANE_TWO:  bw = 4'h2;
			LANE_FOUR: bw = 4'h4;
			default:   bw = 4'h1;
		endcase
	endfunction : bw

	function automatic logic [3:0] present(input fsh_lane_e l, input logic [7:0] b);
		case (l)
			LANE_TWO:  present = {2'h0, b[7], b[6]};
			LANE_FOUR: present = b[7:4];
			default:   present = {2'h0, b[7], 1'b0};
		endcase
	endfunction : present

	function automatic logic [3:0] lane_mask(input fsh_lane_e l);
		case (l)
			LANE_TWO:  lane_mask = 4'h3;
			LANE_FOUR: lane_mask = 4'hF;
			default:   lane_mask = 4'h2;
		endcase
	endfunction : lane_mask

	function automatic logic [1:0] n_dummy(input logic [7:0] op);
		case (op)
			OP_FAST, OP_DUAL_OUT, OP_DUAL_IO, OP_SFDP: n_dummy = 2'h1;
			OP_QUAD_IO: n_dummy = 2'h3; // Mode byte plus 16 dummy bits
			default:    n_dummy = 2'h0;
		endcase
	endfunction : n_dummy

	function automatic logic is_mem(input logic [7:0] op);
		is_mem = (op == OP_READ) || (op == OP_FAST) || (op == OP_DUAL_OUT) || (op == OP_DUAL_IO)
			|| (op == OP_QUAD_IO) || (op == OP_SFDP);
	endfunction : is_mem

	// ==========================================
	// Pin sampling
	logic [5:0] p_raw;
	fsh_pins_s  p;
	fsh_sync #(.W(6)) u_sync (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   ({cs_n_in, sclk_in, dq_in}),
		.q_out  (p_raw)
	);
	assign p = fsh_pins_s'(p_raw);

	// ==========================================
	// State
	fsh_phase_e  ph_r,      ph_nxt;
	fsh_lane_e   aw_r,      aw_nxt;
	fsh_lane_e   dw_r,      dw_nxt;
	logic [7:0]  op_r,      op_nxt;
	logic [7:0]  sh_r,      sh_nxt;
	logic [3:0]  bit_r,     bit_nxt;
	logic [1:0]  idx_r,     idx_nxt;
	logic [1:0]  nbyte_r,   nbyte_nxt;
	logic [23:0] addr_r,    addr_nxt;
	logic [23:0] maddr_r,   maddr_nxt;
	logic [7:0]  out_r,     out_nxt;
	logic [3:0]  obit_r,    obit_nxt;
	logic [1:0]  oidx_r,    oidx_nxt;
	logic [3:0]  dqo_r,     dqo_nxt;
	logic [3:0]  oe_r,      oe_nxt;
	logic        quad_r,    quad_nxt;
	logic        cont_r,    cont_nxt;
	logic        pend_r,    pend_nxt;
	logic        arm_r,     arm_nxt;
	logic        wel_r,     wel_nxt;
	logic        sclk_d_r,  cs_d_r;
	logic        cmdv_r,    cmdv_nxt;
	logic        rxv_r,     rxv_nxt;
	logic [7:0]  rxb_r,     rxb_nxt;
	logic        fend_r,    fend_nxt;
	logic        swr_r,     swr_nxt;
	logic        otpx_r,    otpx_nxt;
	logic        busy_r;

	logic             rise, fall, cs_rise, rx_done, exec, tmr_busy, tmr_load, wel_set, wel_clr;
	fsh_lane_e        lw;
	logic [3:0]       bit_sum;
	logic [7:0]       rx_byte, resp, status_byte;
	logic [TMR_W-1:0] tmr_cnt;

	assign rise        = p.sclk & ~sclk_d_r;
	assign fall        = ~p.sclk & sclk_d_r;
	assign cs_rise     = p.cs_n & ~cs_d_r;
	assign lw          = (ph_r == PH_CMD) ? (quad_r ? LANE_FOUR : LANE_ONE) : aw_r;
	assign bit_sum     = bit_r + bw(lw);
	assign rx_done     = rise && (bit_sum == 4'h8);
	assign exec        = (ph_r == PH_PASS) && (nbyte_r == 2'h1) && (bit_r == 4'h0);
	assign status_byte = {status_hi_in, wel_r, array_busy_in | tmr_busy};

	always_comb
	begin
		case (lw)
			LANE_TWO:  rx_byte = {sh_r[5:0], p.dq[1:0]};
			LANE_FOUR: rx_byte = {sh_r[3:0], p.dq};
			default:   rx_byte = {sh_r[6:0], p.dq[0]};
		endcase
	end

	// Identity and status answers
	always_comb
	begin
		case (op_r)
			OP_STATUS:   resp = status_byte;
			OP_ID_WAKE:  resp = DEV_ID;
			OP_ID_MD:    resp = (oidx_r[0] ^ addr_r[0]) ? DEV_ID : MAKER_ID;
			OP_ID_JEDEC: resp = (oidx_r == 2'h0) ? MAKER_ID : ((oidx_r == 2'h1) ? JEDEC_DEV[15:8] : JEDEC_DEV[7:0]);
			default:     resp = mem_data_in;
		endcase
	end

	fsh_timer #(.W(TMR_W)) u_recov (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.load_in  (tmr_load),
		.count_in (tmr_cnt),
		.busy_out (tmr_busy)
	);

	// ==========================================
	// Frame engine
	always_comb
	begin
		ph_nxt = ph_r;      aw_nxt = aw_r;      dw_nxt = dw_r;      op_nxt = op_r;
		sh_nxt = sh_r;      bit_nxt = bit_r;    idx_nxt = idx_r;    nbyte_nxt = nbyte_r;
		addr_nxt = addr_r;  maddr_nxt = maddr_r; out_nxt = out_r;   obit_nxt = obit_r;
		oidx_nxt = oidx_r;  dqo_nxt = dqo_r;    oe_nxt = oe_r;      quad_nxt = quad_r;
		cont_nxt = cont_r;  pend_nxt = pend_r;  arm_nxt = arm_r;    wel_nxt = wel_r;
		cmdv_nxt = 1'b0;    rxv_nxt = 1'b0;     rxb_nxt = rxb_r;    fend_nxt = 1'b0;
		swr_nxt = 1'b0;     otpx_nxt = 1'b0;    tmr_load = 1'b0;    tmr_cnt = '0;
		wel_set = 1'b0;     wel_clr = write_done_in;
		if (p.cs_n)
		begin
			ph_nxt = PH_IDLE;
			oe_nxt = 4'h0;
			if (cs_rise && ph_r != PH_IDLE)
			begin
				fend_nxt = 1'b1;
				if (op_r == OP_QUAD_IO)
					cont_nxt = pend_r; // Cut or released frames drop continuation
				if (op_r == OP_FIRE)
					arm_nxt = 1'b0;
				if (exec)
				begin
					case (op_r)
						OP_QUAD_ON: quad_nxt = 1'b1;
						OP_BACK:    quad_nxt = 1'b0; // Ignored in single lane
						OP_ARM:     arm_nxt = 1'b1;
						OP_SET_WP:  wel_set = 1'b1;
						OP_CLR_WP:
						begin
							otpx_nxt = otp_mode_in;
							wel_clr = write_done_in | ~otp_mode_in; // Finished write still clears
						end
						OP_FIRE:
						begin
							if (arm_r)
							begin
								swr_nxt = 1'b1;
								quad_nxt = 1'b0;
								cont_nxt = 1'b0;
								wel_clr = 1'b1;
								tmr_load = 1'b1;
								tmr_cnt = array_busy_in ? TMR_W'(RECOV_LONG_CYC) : TMR_W'(RECOV_SHORT_CYC);
							end
						end
						default: ;
					endcase
				end
			end
		end
		else
		begin
			if (rise && ph_r != PH_OUT && ph_r != PH_SKIP && ph_r != PH_IDLE)
			begin
				sh_nxt = rx_byte;
				bit_nxt = rx_done ? 4'h0 : bit_sum;
				if (rx_done && nbyte_r != 2'h3)
					nbyte_nxt = nbyte_r + 2'h1;
			end
			case (ph_r)
				PH_IDLE:
				begin
					bit_nxt = 4'h0;
					nbyte_nxt = 2'h0;
					idx_nxt = 2'h0;
					oidx_nxt = 2'h0;
					obit_nxt = 4'h0;
					pend_nxt = 1'b0;
					if (tmr_busy)
						ph_nxt = PH_SKIP; // Deaf while recovering
					else if (cont_r)
					begin
						op_nxt = OP_QUAD_IO;
						aw_nxt = LANE_FOUR;
						dw_nxt = LANE_FOUR;
						ph_nxt = PH_ADDR;
					end
					else
						ph_nxt = PH_CMD;
				end
				PH_CMD:
				begin
					if (rx_done)
					begin
						op_nxt = rx_byte;
						cmdv_nxt = 1'b1;
						if (rx_byte != OP_FIRE)
							arm_nxt = 1'b0;
						aw_nxt = (quad_r || rx_byte == OP_QUAD_IO) ? LANE_FOUR : ((rx_byte == OP_DUAL_IO) ? LANE_TWO : LANE_ONE);
						dw_nxt = (quad_r || rx_byte == OP_QUAD_IO) ? LANE_FOUR
							: ((rx_byte == OP_DUAL_IO || rx_byte == OP_DUAL_OUT) ? LANE_TWO : LANE_ONE);
						if (deep_pd_in && rx_byte != OP_ID_WAKE)
							ph_nxt = PH_SKIP;
						else if (quad_r && (rx_byte == OP_READ || rx_byte == OP_DUAL_OUT || rx_byte == OP_DUAL_IO))
							ph_nxt = PH_SKIP;
						else if (is_mem(rx_byte) || rx_byte == OP_ID_WAKE || rx_byte == OP_ID_MD)
							ph_nxt = PH_ADDR;
						else if (rx_byte == OP_STATUS || rx_byte == OP_ID_JEDEC)
							ph_nxt = PH_OUT;
						else
							ph_nxt = PH_PASS;
					end
				end
				PH_ADDR:
				begin
					if (rx_done)
					begin
						addr_nxt = {addr_r[15:0], rx_byte};
						idx_nxt = idx_r + 2'h1;
						if (idx_r == 2'h0 && cont_r && rx_byte == ADDR_TOP_BAD)
							ph_nxt = PH_SKIP; // Return command releases continuation
						else if (idx_r == 2'(ADDR_BYTES - 1))
						begin
							maddr_nxt = {addr_r[15:0], rx_byte};
							idx_nxt = 2'h0;
							ph_nxt = (n_dummy(op_r) != 2'h0) ? PH_DUMMY : PH_OUT;
						end
					end
				end
				PH_DUMMY:
				begin
					if (rx_done)
					begin
						if (op_r == OP_QUAD_IO && idx_r == 2'h0)
							pend_nxt = (rx_byte[7:4] == CONT_NIB);
						idx_nxt = idx_r + 2'h1;
						if (idx_r == n_dummy(op_r) - 2'h1)
							ph_nxt = PH_OUT;
					end
				end
				PH_OUT:
				begin
					if (fall)
					begin
						if (obit_r == 4'h0)
						begin
							dqo_nxt = present(dw_r, resp); // Repeats while selected
							out_nxt = resp << bw(dw_r);
							obit_nxt = 4'h8 - bw(dw_r);
							oe_nxt = lane_mask(dw_r);
							oidx_nxt = (op_r == OP_ID_JEDEC && oidx_r == 2'h2) ? 2'h0 : oidx_r + 2'h1;
							if (is_mem(op_r))
								maddr_nxt = maddr_r + 24'h1;
						end
						else
						begin
							dqo_nxt = present(dw_r, out_r);
							out_nxt = out_r << bw(dw_r);
							obit_nxt = obit_r - bw(dw_r);
						end
					end
				end
				PH_PASS:
				begin
					if (rx_done)
					begin
						rxv_nxt = 1'b1;
						rxb_nxt = rx_byte;
					end
				end
				default: ;
			endcase
		end
		if (wel_set)
			wel_nxt = 1'b1;
		else if (wel_clr)
			wel_nxt = 1'b0;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			ph_r <= PH_IDLE;   aw_r <= LANE_ONE;  dw_r <= LANE_ONE;  op_r <= 8'h00;
			sh_r <= 8'h00;     bit_r <= 4'h0;     idx_r <= 2'h0;     nbyte_r <= 2'h0;
			addr_r <= 24'h0;   maddr_r <= 24'h0;  out_r <= 8'h00;    obit_r <= 4'h0;
			oidx_r <= 2'h0;    dqo_r <= 4'h0;     oe_r <= 4'h0;      quad_r <= QUAD_RST;
			cont_r <= 1'b0;    pend_r <= 1'b0;    arm_r <= 1'b0;     wel_r <= WP_RST;
			sclk_d_r <= 1'b1;  cs_d_r <= 1'b1;    cmdv_r <= 1'b0;    rxv_r <= 1'b0;
			rxb_r <= 8'h00;    fend_r <= 1'b0;    swr_r <= 1'b0;     otpx_r <= 1'b0;
			busy_r <= 1'b0;
		end
		else
		begin
			ph_r <= ph_nxt;    aw_r <= aw_nxt;    dw_r <= dw_nxt;    op_r <= op_nxt;
			sh_r <= sh_nxt;    bit_r <= bit_nxt;  idx_r <= idx_nxt;  nbyte_r <= nbyte_nxt;
			addr_r <= addr_nxt; maddr_r <= maddr_nxt; out_r <= out_nxt; obit_r <= obit_nxt;
			oidx_r <= oidx_nxt; dqo_r <= dqo_nxt; oe_r <= oe_nxt;    quad_r <= quad_nxt;
			cont_r <= cont_nxt; pend_r <= pend_nxt; arm_r <= arm_nxt; wel_r <= wel_nxt;
			sclk_d_r <= p.sclk; cs_d_r <= p.cs_n; cmdv_r <= cmdv_nxt; rxv_r <= rxv_nxt;
			rxb_r <= rxb_nxt;  fend_r <= fend_nxt; swr_r <= swr_nxt; otpx_r <= otpx_nxt;
			busy_r <= array_busy_in | tmr_busy;
		end
	end

	assign dq_out                     = dqo_r;
	assign dq_oe_out                  = oe_r;
	assign mem_addr_out               = maddr_r;
	assign cmd_valid_out              = cmdv_r;
	assign cmd_opcode_out             = op_r;
	assign rx_valid_out               = rxv_r;
	assign rx_byte_out                = rxb_r;
	assign frame_end_out              = fend_r;
	assign sw_reset_out               = swr_r;
	assign otp_exit_out               = otpx_r;
	assign four_lane_mode_out         = quad_r;
	assign quad_read_continuation_out = cont_r;
	assign write_permit_out           = wel_r;
	assign busy_out                   = busy_r;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	dual_lane_a: assert property (oe_r == 4'h3 && ph_r == PH_OUT && fall && obit_r != 4'h0
		|=> dq_out[1:0] == $past(out_r[7:6])) else $error("dual lane order wrong");
	quad_lane_a: assert property (oe_r == 4'hF && ph_r == PH_OUT && fall && obit_r != 4'h0
		|=> dq_out == $past(out_r[7:4])) else $error("quad lane order wrong");
	quad_entry_a: assert property (cs_rise && exec && op_r == OP_QUAD_ON |=> quad_r)
		else $error("four lane mode not entered");
	quad_block_a: assert property (quad_r && ph_r == PH_CMD && rx_done && rx_byte == OP_DUAL_IO
		|=> ph_r == PH_SKIP) else $error("dual read accepted in four lane mode");
	back_single_a: assert property (cs_rise && exec && op_r == OP_BACK && !arm_r |=> !quad_r)
		else $error("return command left four lane mode on");
	arm_cancel_a: assert property (ph_r == PH_CMD && rx_done && rx_byte != OP_FIRE |=> !arm_r)
		else $error("reset arm survived other command");
	reset_state_a: assert property (swr_r |-> !quad_r && !cont_r && !wel_r ##1 busy_out)
		else $error("software reset left state behind");
	recov_long_a: assert property (swr_r && $past(array_busy_in) |-> ##270 busy_out)
		else $error("recovery after write too short");
	wel_set_a: assert property (cs_rise && exec && op_r == OP_SET_WP |=> wel_r)
		else $error("write permit not set");
	wel_auto_a: assert property (write_done_in && !(cs_rise && exec && op_r == OP_SET_WP) |=> !wel_r)
		else $error("write permit not cleared after write");
	status_rep_a: assert property (ph_r == PH_OUT && op_r == OP_STATUS && fall && obit_r == 4'h0
		&& dw_r == LANE_ONE |=> dq_out[1] == $past(status_byte[7]) && dq_oe_out == 4'h2)
		else $error("status byte not driven");
endmodule : fsh_ctl
`default_nettype wire

// ==== hw/fsh_pkg.sv ====
package fsh_pkg;

	// ==========================================
	// Opcodes
	localparam logic [7:0] OP_QUAD_ON    = 8'h38;
	localparam logic [7:0] OP_BACK       = 8'hFF;
	localparam logic [7:0] OP_ARM        = 8'h66;
	localparam logic [7:0] OP_FIRE       = 8'h99;
	localparam logic [7:0] OP_SET_WP     = 8'h06;
	localparam logic [7:0] OP_CLR_WP     = 8'h04;
	localparam logic [7:0] OP_STATUS     = 8'h05;
	localparam logic [7:0] OP_READ       = 8'h03;
	localparam logic [7:0] OP_FAST       = 8'h0B;
	localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
	localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
	localparam logic [7:0] OP_QUAD_IO    = 8'hEB;
	localparam logic [7:0] OP_SFDP       = 8'h5A;
	localparam logic [7:0] OP_ID_WAKE    = 8'hAB;
	localparam logic [7:0] OP_ID_MD      = 8'h90;
	localparam logic [7:0] OP_ID_JEDEC   = 8'h9F;

	// ==========================================
	// Field values and reset values
	localparam logic [3:0] CONT_NIB      = 4'hA;
	localparam logic [7:0] ADDR_TOP_BAD  = 8'hFF;
	localparam logic       WP_RST        = 1'b0;
	localparam logic       QUAD_RST      = 1'b0;
	localparam int         ADDR_BYTES    = 3;
	localparam int         BUSY_BIT      = 0;
	localparam int         WP_BIT        = 1;

	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS   = 100;
	localparam int RECOV_LONG_NS   = 28000;
	localparam int RECOV_SHORT_NS  = 1000;
	localparam int TMR_W           = 9;
	localparam int RECOV_LONG_CYC  = (RECOV_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOV_SHORT_CYC = (RECOV_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================
	// Types
	typedef enum logic [1:0] {LANE_ONE, LANE_TWO, LANE_FOUR} fsh_lane_e;
	typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_DUMMY, PH_OUT, PH_PASS, PH_SKIP} fsh_phase_e;

	typedef struct packed {
		logic       cs_n;
		logic       sclk;
		logic [3:0] dq;
	} fsh_pins_s;

endpackage : fsh_pkg

// ==== hw/fsh_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsh_sync #(
	parameter int W = 1
)(
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] hold_r;
	logic [W-1:0] hold_nxt;

	// Refused at elaboration, not left to a run
	if (W < 1)
	begin : g_bad_w
		$error("fsh_sync: W must be at least 1");
	end

	// ==========================================
	// Two stages; only the second is read
	always_comb
	begin
		meta_nxt = d_in;
		hold_nxt = meta_r;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			meta_r <= '1;
			hold_r <= '1;
		end
		else
		begin
			meta_r <= meta_nxt;
			hold_r <= hold_nxt;
		end
	end

	assign q_out = hold_r;
endmodule : fsh_sync
`default_nettype wire

// ==== hw/fsh_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsh_timer #(
	parameter int W = 9
)(
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic         load_in,
	input  wire logic [W-1:0] count_in,
	output logic              busy_out
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	if (W < 2)
	begin : g_bad_w
		$error("fsh_timer: W must be at least 2");
	end

	// ==========================================
	// Down counter, reload wins
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (load_in)
			cnt_nxt = count_in;
		else if (cnt_r != '0)
			cnt_nxt = cnt_r - 1'b1;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	assign busy_out = (cnt_r != '0);
endmodule : fsh_timer
`default_nettype wire

// ==== bench/fsh_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsh_host(
	input  wire logic       clk_in,
	input  wire logic [3:0] dq_in,
	output logic            cs_n_out,
	output logic            sclk_out,
	output logic [3:0]      dq_out
);
	// ==========================================
	// Host side of the link
	initial
	begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		dq_out   = 4'hA;
	end

	// Released lanes toggle so a stale level never passes for data
	task automatic tick(input logic [3:0] m, input logic [3:0] v);
		@(posedge clk_in);
		dq_out <= (v & m) | (~dq_out & ~m);
	endtask : tick

	task automatic idle(input int n);
		repeat (n) tick(4'h0, 4'h0);
	endtask : idle

	task automatic start();
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		idle(4);
	endtask : start

	task automatic stop();
		idle(4);
		cs_n_out <= 1'b1;
		idle(8);
	endtask : stop

	// Width follows the current mode, so the reset pair keeps it too
	task automatic shift(input logic [7:0] tx, input int w, input bit drv, output logic [7:0] rx);
		logic [7:0] s;
		logic [3:0] m;
		logic [3:0] v;
		s  = tx;
		rx = 8'h00;
		m  = !drv ? 4'h0 : (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
		repeat (8 / w)
		begin
			v = (w == 4) ? s[7:4] : (w == 2) ? {2'b00, s[7:6]} : {3'b000, s[7]};
			repeat (4) tick(m, v);
			sclk_out <= 1'b1;
			repeat (4) tick(m, v);
			rx = (w == 4) ? {rx[3:0], dq_in} : (w == 2) ? {rx[5:0], dq_in[1:0]} : {rx[6:0], dq_in[1]};
			sclk_out <= 1'b0;
			s = s << w;
		end
	endtask : shift
endmodule : fsh_host
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench import fsh_pkg::*;;
	localparam logic [7:0]  M_ID = 8'h6E;    // Arbitrary value
	localparam logic [7:0]  D_ID = 8'h91;    // Arbitrary value
	localparam logic [15:0] J_ID = 16'h3B07; // Arbitrary value
	logic clk_in, rst_in, busy_in, wdone, otp, clr;
	logic [5:0] st_hi;
	logic [7:0] mdat, r;
	logic cs_n, sclk, perm, quad, busy, swr, otpx;
	logic dpd, cont, fend, cmdv, rxv;
	logic [7:0] opc, rxb;
	logic [23:0] maddr;
	logic [3:0] hdq, ddq, doe, dq_w, oe_seen;
	int n_fail, n_checks, n_rst, n_otp, n_fend, n_cmdv, n_rxv;

	// ==========================================
	// Wiring and monitors
	assign dq_w = (doe & ddq) | (~doe & hdq);
	fsh_host host(.clk_in(clk_in), .dq_in(dq_w), .cs_n_out(cs_n), .sclk_out(sclk), .dq_out(hdq));
	fsh_ctl #(.MAKER_ID(M_ID), .DEV_ID(D_ID), .JEDEC_DEV(J_ID)) dut(.clk_in(clk_in), .rst_in(rst_in),
		.cs_n_in(cs_n), .sclk_in(sclk), .dq_in(dq_w), .dq_out(ddq), .dq_oe_out(doe),
		.array_busy_in(busy_in), .write_done_in(wdone), .otp_mode_in(otp), .deep_pd_in(dpd),
		.status_hi_in(st_hi), .mem_data_in(mdat), .mem_addr_out(maddr), .cmd_valid_out(cmdv),
		.cmd_opcode_out(opc), .rx_valid_out(rxv), .rx_byte_out(rxb), .frame_end_out(fend), .sw_reset_out(swr),
		.otp_exit_out(otpx), .four_lane_mode_out(quad), .quad_read_continuation_out(cont),
		.write_permit_out(perm), .busy_out(busy));

	initial
	begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	always @(posedge clk_in)
	begin
		oe_seen <= clr ? 4'h0 : oe_seen | doe;
		n_rst   <= clr ? 0 : n_rst + int'(swr);
		n_otp   <= clr ? 0 : n_otp + int'(otpx);
		n_fend  <= clr ? 0 : n_fend + int'(fend);
		n_cmdv  <= clr ? 0 : n_cmdv + int'(cmdv);
		n_rxv   <= clr ? 0 : n_rxv + int'(rxv);
	end

	// ==========================================
	// Helpers
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic complete_run();
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	task automatic cmd(input logic [7:0] op, input int w);
		host.start();
		host.shift(op, w, 1'b1, r);
		host.stop();
	endtask : cmd

	task automatic zero();
		clr <= 1'b1;
		@(posedge clk_in);
		clr <= 1'b0;
	endtask : zero

	task automatic idcheck(input logic [7:0] op, input int nd, input int nb, input logic [23:0] exp);
		host.start();
		host.shift(op, 1, 1'b1, r);
		repeat (nd) host.shift(8'h00, 1, 1'b1, r);
		for (int k = 0; k < nb; k++)
		begin
			host.shift(8'h00, 1, 1'b0, r);
			chk(r, exp[23-8*k -: 8]);
		end
		host.stop();
	endtask : idcheck

	// ==========================================
	// Scenarios
	task automatic t_permit();
		cmd(OP_SET_WP, 1);
		chk(perm, 1'b1);
		host.start();
		host.shift(OP_STATUS, 1, 1'b1, r);
		host.shift(8'h00, 1, 1'b0, r);
		chk(r, {st_hi, 2'b10});
		host.shift(8'h00, 1, 1'b0, r);
		chk(r, {st_hi, 2'b10});
		host.stop();
		@(posedge clk_in) wdone <= 1'b1;
		@(posedge clk_in) wdone <= 1'b0;
		host.idle(2);
		chk(perm, 1'b0);
		busy_in <= 1'b1;
		host.start();
		host.shift(OP_STATUS, 1, 1'b1, r);
		host.shift(8'h00, 1, 1'b0, r);
		chk(r, {st_hi, 2'b01});
		host.stop();
		busy_in <= 1'b0;
		cmd(OP_SET_WP, 1);
		otp <= 1'b1;
		zero();
		cmd(OP_CLR_WP, 1);
		chk(n_otp, 1);
		otp <= 1'b0;
		cmd(OP_CLR_WP, 1);
		chk(perm, 1'b0);
		zero();
		host.start();
		host.shift(8'h01, 1, 1'b1, r);
		host.shift(8'h3C, 1, 1'b1, r);
		host.stop();
		chk(opc, 8'h01);
		chk({n_cmdv[1:0], n_fend[1:0], n_rxv[1:0]}, 6'h15);
		chk(rxb, 8'h3C);
	endtask : t_permit

	// Deep power-down: only the identity wake read is served
	task automatic t_deep();
		dpd <= 1'b1;
		zero();
		cmd(OP_SET_WP, 1);
		cmd(OP_ARM, 1);
		cmd(OP_FIRE, 1);
		chk({perm, n_rst != 0}, 2'b00);
		idcheck(OP_ID_WAKE, 3, 1, {D_ID, 16'h0000});
		dpd <= 1'b0;
	endtask : t_deep

	task automatic t_dual();
		mdat <= 8'hC6;
		host.start();
		host.shift(OP_DUAL_OUT, 1, 1'b1, r);
		repeat (4) host.shift(8'h00, 1, 1'b1, r);
		host.shift(8'h00, 2, 1'b0, r);
		chk(r, 8'hC6);
		host.stop();
	endtask : t_dual

	task automatic t_quad();
		cmd(OP_QUAD_ON, 1);
		chk(quad, 1'b1);
		zero();
		host.start();
		repeat (4) host.shift(OP_READ, 4, 1'b1, r);
		host.shift(8'h00, 4, 1'b0, r);
		host.stop();
		chk(oe_seen, 4'h0);
		cmd(OP_SET_WP, 4);
		chk(perm, 1'b1);
		host.start();
		host.shift(OP_STATUS, 4, 1'b1, r);
		host.shift(8'h00, 4, 1'b0, r);
		chk(r, {st_hi, 2'b10});
		host.stop();
		zero();
		cmd(OP_ARM, 4);
		cmd(OP_SET_WP, 4);
		cmd(OP_FIRE, 4);
		chk(n_rst, 0);
		cmd(OP_ARM, 4);
		cmd(OP_FIRE, 4);
		chk(n_rst, 1);
		chk(quad, 1'b0);
		chk(perm, 1'b0);
		chk(busy, 1'b1);
		host.idle(20);
		chk(busy, 1'b0);
		cmd(OP_QUAD_ON, 1);
		cmd(OP_BACK, 4);
		chk(quad, 1'b0);
		cmd(OP_QUAD_ON, 1);
		mdat <= 8'h5C;
		qread(1'b1);
		mdat <= 8'hA3;
		qread(1'b0);
		cmd(OP_BACK, 4);
		chk({cont, quad}, 2'b01);
		cmd(OP_BACK, 4);
		chk({cont, quad}, 2'b00);
	endtask : t_quad

	// Quad read with continuation nibble; without opcode once continuing
	task automatic qread(input bit with_op);
		host.start();
		if (with_op)
			host.shift(OP_QUAD_IO, 4, 1'b1, r);
		host.shift(8'h12, 4, 1'b1, r);
		host.shift(8'h34, 4, 1'b1, r);
		host.shift(8'h56, 4, 1'b1, r);
		host.shift({CONT_NIB, 4'h0}, 4, 1'b1, r);
		repeat (2) host.shift(8'h00, 4, 1'b1, r);
		host.shift(8'h00, 4, 1'b0, r);
		host.stop();
		chk({cont, r}, {1'b1, mdat});
		chk(maddr, 24'h123458);
	endtask : qread

	// Mode unknown: quad pair, then single pair, from either mode
	task automatic t_unsure();
		for (int k = 0; k < 2; k++)
		begin
			if (k == 0)
				cmd(OP_QUAD_ON, 1);
			zero();
			cmd(OP_ARM, 4);
			cmd(OP_FIRE, 4);
			cmd(OP_ARM, 1);
			cmd(OP_FIRE, 1);
			chk({quad, n_rst != 0}, 2'b01);
			host.idle(20);
		end
	endtask : t_unsure

	// Reset while a write runs needs the long recovery
	task automatic t_recover();
		busy_in <= 1'b1;
		cmd(OP_ARM, 1);
		cmd(OP_FIRE, 1);
		busy_in <= 1'b0;
		host.idle(100);
		chk(busy, 1'b1);
		host.idle(200);
		chk(busy, 1'b0);
	endtask : t_recover

	// ==========================================
	// Main sequence and watchdog
	initial
	begin
		rst_in = 1'b1;
		busy_in = 1'b0;
		wdone = 1'b0;
		otp = 1'b0;
		dpd = 1'b0;
		clr = 1'b1;
		st_hi = 6'h2D;
		mdat = 8'h00;
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		clr <= 1'b0;
		host.idle(4);
		chk({quad, perm}, 2'b00);
		t_permit();
		idcheck(OP_ID_JEDEC, 0, 3, {M_ID, J_ID});
		idcheck(OP_ID_MD, 3, 2, {M_ID, D_ID, 8'h00});
		idcheck(OP_ID_WAKE, 3, 1, {D_ID, 16'h0000});
		t_deep();
		t_dual();
		t_quad();
		t_unsure();
		t_recover();
		complete_run();
	end

	// Whole run needs well under a millisecond
	initial
	begin
		#2000000;
		n_fail++;
		complete_run();
	end
endmodule : testbench
`default_nettype wire
